// file: core/irq_ctrl_regs.svh
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// ====================================================
// Register byte offsets
`define IRQ_FLAG_OFS 12'h000
`define IRQ_ENABLE_OFS 12'h004
`define IRQ_SH_ACC_OFS 12'h008
`define IRQ_SH_STATUS_OFS 12'h00C
`define IRQ_SH_FSR_OFS 12'h010
`define IRQ_SH_BANK_OFS 12'h014
`define IRQ_CTX_STATE_OFS 12'h018

// ====================================================
// Field positions
`define IRQ_ADC_BIT 7
`define IRQ_CMP_BIT 6
`define IRQ_TMR_BIT 5
`define IRQ_PIN_BIT 4
`define IRQ_GIE_BIT 0
`define IRQ_WUR_BIT 0
`define IRQ_IMPL_MASK 8'hF1
`define IRQ_RESET_VALUE 8'h00
`define IRQ_VECTOR_ADDR 11'h004
`endif

// file: core/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
	// Events from peripherals, one cycle pulses
	typedef struct packed {
		logic adc_done;
		logic adc_abort;
		logic cmp1_change;
		logic cmp2_change;
		logic tmr_overflow;
		logic pin_change;
	} periph_events_t;

	// Core context register set
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] status;
		logic [7:0] indirect_pointer;
		logic [7:0] bank;
	} context_t;

	typedef enum logic [1:0] {
		ST_MAIN = 2'b00,
		ST_ISR = 2'b01,
		ST_WAKE_PEND = 2'b10
	} irq_state_t;
endpackage : irq_ctrl_pkg

// file: core/irq_ctrl_ctx_switch.sv
// The address map and the AHB-Lite register port were chosen for this implementation.
`include "irq_ctrl_regs.svh"

module irq_ctrl_ctx_switch (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Peripheral events and wake qualifiers
	input wire irq_ctrl_pkg::periph_events_t events,
	input wire logic cmp1_wake_disable_n,
	input wire logic cmp2_wake_disable_n,
	input wire logic pin_wake_disable_n,
	input wire logic [3:0] runs_in_sleep,
	// Core side
	input wire logic core_sleeping,
	input wire logic instr_boundary,
	input wire logic return_from_isr,
	input wire irq_ctrl_pkg::context_t core_ctx_in,
	input wire logic core_ctx_we,
	output irq_ctrl_pkg::context_t core_ctx_out,
	output logic vector_take,
	output logic [10:0] vector_addr,
	output logic flush_prefetch,
	output logic push_pc,
	output logic pop_pc,
	output logic wake_inline,
	output logic wake_reset,
	output logic in_isr
);
	// ====================================================
	// Register state
	// Only the four flag bits are stored; bits 3 to 1 are tied low at the read mux,
	// so no variable has two kinds of driver.
	// Limitation: hsize is ignored and every access moves a whole word, low byte used.
	// Limitation: the shadow sets have no reset, so firmware must load them before use.
	logic [7:4] flags;
	logic global_irq_enable;
	logic [7:0] enables;
	irq_ctrl_pkg::context_t ctx_main;
	irq_ctrl_pkg::context_t ctx_isr;
	irq_ctrl_pkg::irq_state_t state;
	logic [3:0] slept_enables;
	logic was_sleeping;

	// ====================================================
	// Bus address phase capture
	logic wr_pend;
	logic [11:0] wr_addr;
	logic addr_valid;
	assign addr_valid = hsel && hready && htrans[1];

	// Write strobe for the data phase that follows an accepted address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wr_pend <= 1'b0;
		else
			wr_pend <= addr_valid && hwrite;
	end

	// Address kept for the data phase; only meaningful while wr_pend is high
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wr_addr <= 12'h000;
		else
			wr_addr <= haddr;
	end

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	logic wr_flag;
	logic wr_en;
	logic [7:0] wdat;
	assign wdat = hwdata[7:0];
	assign wr_flag = wr_pend && (wr_addr == `IRQ_FLAG_OFS);
	assign wr_en = wr_pend && (wr_addr == `IRQ_ENABLE_OFS);

	// ====================================================
	// Event qualification
	logic [3:0] set_ev;
	always_comb
	begin
		set_ev = 4'h0;
		set_ev[3] = events.adc_done && !events.adc_abort;
		set_ev[2] = (events.cmp1_change && !cmp1_wake_disable_n)
			|| (events.cmp2_change && !cmp2_wake_disable_n);
		set_ev[1] = events.tmr_overflow;
		set_ev[0] = events.pin_change && !pin_wake_disable_n;
	end

	// Pending and enabled sources
	logic [3:0] armed;
	assign armed = flags[7:4] & enables[7:4];

	logic take;
	logic wake_any;
	// Sleeping core wakes on sources enabled before sleep that can run clockless
	assign wake_any = core_sleeping && |(armed & slept_enables & runs_in_sleep);
	// Take only between instructions and only while the core is awake, from the first boundary after a wake
	assign take = global_irq_enable && |armed && instr_boundary && !core_sleeping
		&& (state == irq_ctrl_pkg::ST_MAIN);

	// ====================================================
	// Flag bits: set wins over a software clear
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_flag
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					flags[gi + 4] <= 1'b0;
				else if (set_ev[gi])
					flags[gi + 4] <= 1'b1;
				else if (wr_flag)
					flags[gi + 4] <= wdat[gi + 4];
			end
		end
	endgenerate

	// Global enable: cleared on take, set on return, else software
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			global_irq_enable <= 1'b0;
		else if (take)
			global_irq_enable <= 1'b0;
		else if (return_from_isr && state == irq_ctrl_pkg::ST_ISR)
			global_irq_enable <= 1'b1;
		else if (wr_flag)
			global_irq_enable <= wdat[`IRQ_GIE_BIT];
	end

	// Source enables and wake-reset enable
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			enables <= `IRQ_RESET_VALUE;
		else if (wr_en)
			enables <= wdat & `IRQ_IMPL_MASK;
	end

	// Enables latched on sleep entry
	// Sleep level of the previous cycle, to find the entry edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			was_sleeping <= 1'b0;
		else
			was_sleeping <= core_sleeping;
	end

	// Enables set after sleep entry must not wake the core, so they are frozen here
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			slept_enables <= 4'h0;
		else if (core_sleeping && !was_sleeping)
			slept_enables <= enables[7:4];
	end

	// ====================================================
	// Service state
	// Next state worked out apart so the take and return decodes stay visible
	irq_ctrl_pkg::irq_state_t next_state;
	always_comb
	begin
		next_state = state;
		case (state)
			irq_ctrl_pkg::ST_MAIN:
			begin
				if (take)
					next_state = irq_ctrl_pkg::ST_ISR;
			end
			irq_ctrl_pkg::ST_ISR:
			begin
				if (return_from_isr)
					next_state = irq_ctrl_pkg::ST_MAIN;
			end
			// Wake-pending code is unused; any odd code falls back to main line
			default:
				next_state = irq_ctrl_pkg::ST_MAIN;
		endcase
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state <= irq_ctrl_pkg::ST_MAIN;
		else
			state <= next_state;
	end
	assign in_isr = (state == irq_ctrl_pkg::ST_ISR);

	// Contexts: no reset, power-up contents unknown
	always_ff @(posedge hclk)
	begin
		if (core_ctx_we && !in_isr)
			ctx_main <= core_ctx_in;
	end

	always_ff @(posedge hclk)
	begin
		if (core_ctx_we && in_isr)
			ctx_isr <= core_ctx_in;
	end

	assign core_ctx_out = in_isr ? ctx_isr : ctx_main;

	// ====================================================
	// Wake decision
	// Reset wake outranks inline; a vectored wake is an inline wake plus a later take
	logic next_wake_reset;
	logic next_wake_inline;
	always_comb
	begin
		next_wake_reset = 1'b0;
		next_wake_inline = 1'b0;
		if (wake_any)
		begin
			if (enables[`IRQ_WUR_BIT])
				next_wake_reset = 1'b1;
			else
				next_wake_inline = 1'b1;
		end
	end

	// A return outside the routine is ignored so a stray pop cannot upset the stack
	logic ret_ok;
	assign ret_ok = return_from_isr && in_isr;

	// ====================================================
	// Core control outputs, registered: redirect pulses, fixed vector and wake levels
	// Redirect strobe, one cycle after the take
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			vector_take <= 1'b0;
		else
			vector_take <= take;
	end

	// Prefetched instruction is dropped with the redirect
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flush_prefetch <= 1'b0;
		else
			flush_prefetch <= take;
	end

	// Return address goes on the stack with the redirect
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			push_pc <= 1'b0;
		else
			push_pc <= take;
	end

	// Stacked address comes back on a valid return
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pop_pc <= 1'b0;
		else
			pop_pc <= ret_ok;
	end

	// Fixed vector, stable from the first clock after reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			vector_addr <= 11'h000;
		else
			vector_addr <= `IRQ_VECTOR_ADDR;
	end

	// Reset wake level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wake_reset <= 1'b0;
		else
			wake_reset <= next_wake_reset;
	end

	// Inline wake level; the vector, if any, follows through a normal take
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wake_inline <= 1'b0;
		else
			wake_inline <= next_wake_inline;
	end

	// ====================================================
	// Read data, registered in the data phase
	// Shadow view shows the context not in use; may be unknown until first written
	irq_ctrl_pkg::context_t ctx_shadow;
	assign ctx_shadow = in_isr ? ctx_main : ctx_isr;

	logic [7:0] rd_byte;
	always_comb
	begin
		rd_byte = 8'h00;
		case (haddr)
			`IRQ_FLAG_OFS: rd_byte = {flags[7:4], 3'b000, global_irq_enable};
			`IRQ_ENABLE_OFS: rd_byte = enables;
			`IRQ_SH_ACC_OFS: rd_byte = ctx_shadow.acc;
			`IRQ_SH_STATUS_OFS: rd_byte = ctx_shadow.status;
			`IRQ_SH_FSR_OFS: rd_byte = ctx_shadow.indirect_pointer;
			`IRQ_SH_BANK_OFS: rd_byte = ctx_shadow.bank;
			`IRQ_CTX_STATE_OFS: rd_byte = {7'h00, in_isr};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (addr_valid && !hwrite)
			hrdata <= {24'h000000, rd_byte};
	end
endmodule : irq_ctrl_ctx_switch

// file: testbench/irq_ctrl_ctx_switch_assertions.sv
// ========
// Core side checks
module irq_assert_chk (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Core side
	input wire logic core_sleeping,
	input wire logic instr_boundary,
	input wire logic return_from_isr,
	input wire logic vector_take,
	input wire logic [10:0] vector_addr,
	input wire logic flush_prefetch,
	input wire logic push_pc,
	input wire logic pop_pc,
	input wire logic wake_inline,
	input wire logic wake_reset,
	input wire logic in_isr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// A take redirects fully or not at all
	take_side_a: assert property (vector_take |-> flush_prefetch && push_pc && vector_addr == 11'h004)
		else $error("bad take");
	take_cause_a: assert property (vector_take |-> $past(instr_boundary && !core_sleeping && !in_isr))
		else $error("stray take");
	take_isr_a: assert property (vector_take |-> in_isr) else $error("no isr");
	no_nest_a: assert property (in_isr && $past(in_isr) |-> !vector_take) else $error("nested");
	ret_exit_a: assert property (return_from_isr && in_isr |=> pop_pc && !in_isr) else $error("bad ret");
	pop_cause_a: assert property (pop_pc |-> $past(return_from_isr && in_isr)) else $error("stray pop");
	// Registered wake levels may trail the sleep level by one cycle
	wake_sleep_a: assert property (wake_inline || wake_reset |-> core_sleeping || $past(core_sleeping))
		else $error("stray wake");
	wake_excl_a: assert property (!(wake_inline && wake_reset)) else $error("two wakes");
endmodule : irq_assert_chk

bind irq_ctrl_ctx_switch irq_assert_chk chk (.hclk, .hresetn, .core_sleeping, .instr_boundary, .return_from_isr,
	.vector_take, .vector_addr, .flush_prefetch, .push_pc, .pop_pc, .wake_inline, .wake_reset, .in_isr);

// file: testbench/core_model.sv
// ========
// CPU core stand-in
module core_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bench commands
	input wire logic ret_req,
	input wire logic ctx_req,
	input wire irq_ctrl_pkg::context_t ctx_val,
	// Core pins
	input wire logic in_isr,
	input wire logic core_sleeping,
	output logic instr_boundary,
	output logic return_from_isr,
	output irq_ctrl_pkg::context_t core_ctx_in,
	output logic core_ctx_we
);
	timeunit 1ns;
	timeprecision 1ps;
	// Return only from inside the routine; idle data toggles so stale values show
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			return_from_isr <= 1'b0;
			core_ctx_we <= 1'b0;
			core_ctx_in <= '0;
		end
		else
		begin
			return_from_isr <= ret_req && in_isr;
			core_ctx_we <= ctx_req;
			core_ctx_in <= ctx_req ? ctx_val : ~core_ctx_in;
		end
	end
	// No instruction completes while asleep
	assign instr_boundary = !core_sleeping;
endmodule : core_model

// file: testbench/irq_ctrl_ctx_switch_tb.sv
`include "irq_ctrl_regs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module irq_ctrl_ctx_switch_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// Signals
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic [11:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0, hrdata, rd;
	wire hready = hreadyout;
	irq_ctrl_pkg::periph_events_t events = '0;
	logic cmp1_wake_disable_n = 1, cmp2_wake_disable_n = 1, pin_wake_disable_n = 1, core_sleeping = 0;
	logic [3:0] runs_in_sleep = 4'hF;
	logic ret_req = 0, ctx_req = 0, instr_boundary, return_from_isr, core_ctx_we, vector_take, flush_prefetch;
	logic push_pc, pop_pc, wake_inline, wake_reset, in_isr;
	logic [10:0] vector_addr;
	irq_ctrl_pkg::context_t ctx_val = '0, core_ctx_in, core_ctx_out, main_ctx;
	int mismatches = 0, comparisons = 0, m_en;
	irq_ctrl_pkg::periph_events_t evs[8] = '{6'h20, 6'h02, 6'h30, 6'h08, 6'h01, 6'h08, 6'h04, 6'h01};
	int exps[8] = '{'h80, 'h20, 0, 0, 0, 'h40, 'h40, 'h10};

	irq_ctrl_ctx_switch dut (.*);
	core_model core (.*);

	// Clock, 4 ns period
	always #2 hclk = ~hclk;

	// ========
	// Tasks
	task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task automatic rchk(input string n, input logic [11:0] a, input int e);
		xfer(0, a, 0);
		`CHK(n, 32'(e), rd)
	endtask : rchk
	task automatic ev(input irq_ctrl_pkg::periph_events_t e);
		events <= e;
		@(posedge hclk);
		events <= '0;
		@(posedge hclk);
	endtask : ev
	task automatic core_cmd(input bit r, input irq_ctrl_pkg::context_t c);
		ctx_val <= c;
		ret_req <= r;
		ctx_req <= !r;
		@(posedge hclk);
		{ret_req, ctx_req} <= 2'b00;
		repeat (3) @(posedge hclk);
	endtask : core_cmd
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// Watchdog, far beyond the roughly 150 cycles the tests need
	initial
	begin
		#20000;
		mismatches++;
		wrap_up();
	end

	// ========
	// Main sequence
	initial
	begin
		void'($urandom(32'hedd7));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rchk("flags", `IRQ_FLAG_OFS, 0);
		rchk("enables", `IRQ_ENABLE_OFS, 0);
		m_en = $urandom & 'hF1;
		xfer(1, `IRQ_ENABLE_OFS, 32'(m_en) | 32'hE);
		rchk("en", `IRQ_ENABLE_OFS, m_en);
		xfer(1, `IRQ_ENABLE_OFS, 0);
		xfer(1, `IRQ_FLAG_OFS, 32'hE);
		rchk("flag rsv", `IRQ_FLAG_OFS, 0);
		$display("registers done");
		// Sources, gating and clearing with all enables off
		foreach (evs[i])
		begin
			{cmp1_wake_disable_n, cmp2_wake_disable_n, pin_wake_disable_n} <= {3{i < 5}};
			ev(evs[i]);
			rchk("flag set", `IRQ_FLAG_OFS, exps[i]);
			xfer(1, `IRQ_FLAG_OFS, 0);
			rchk("flag clr", `IRQ_FLAG_OFS, 0);
		end
		// Event lands on the same edge as a clearing write
		fork
			xfer(1, `IRQ_FLAG_OFS, 0);
			begin
				@(posedge hclk);
				ev(6'h02);
			end
		join
		rchk("set wins", `IRQ_FLAG_OFS, 'h20);
		$display("flags done");
		// Pending and enabled, but global enable clear
		xfer(1, `IRQ_ENABLE_OFS, 32'h20);
		main_ctx = $urandom;
		core_cmd(0, main_ctx);
		`CHK("held", 1'b0, in_isr)
		xfer(1, `IRQ_FLAG_OFS, 32'h21);
		repeat (3) @(posedge hclk);
		`CHK("take", 1'b1, in_isr)
		rchk("gie clr", `IRQ_FLAG_OFS, 'h20);
		core_cmd(0, ~main_ctx);
		rchk("shadow", `IRQ_SH_ACC_OFS, main_ctx.acc);
		`CHK("isr ctx", ~main_ctx, core_ctx_out)
		// Return with the flag still pending is taken again
		core_cmd(1, '0);
		`CHK("retake", 1'b1, in_isr)
		xfer(1, `IRQ_FLAG_OFS, 0);
		core_cmd(1, '0);
		`CHK("exit", 1'b0, in_isr)
		`CHK("main ctx", main_ctx, core_ctx_out)
		rchk("gie set", `IRQ_FLAG_OFS, 'h01);
		xfer(1, `IRQ_FLAG_OFS, 0);
		$display("service done");
		// Wake kinds: inline, reset, and a source that cannot run asleep
		for (int i = 0; i < 3; i++)
		begin
			xfer(1, `IRQ_ENABLE_OFS, 32'h20 | 32'(i == 1));
			runs_in_sleep <= (i == 2) ? 4'h0 : 4'hF;
			core_sleeping <= 1'b1;
			@(posedge hclk);
			ev(6'h02);
			@(posedge hclk);
			`CHK("wake rst", 1'(i == 1), wake_reset)
			`CHK("wake inl", 1'(i == 0), wake_inline)
			core_sleeping <= 1'b0;
			xfer(1, `IRQ_FLAG_OFS, 0);
		end
		$display("sleep done");
		wrap_up();
	end
endmodule : irq_ctrl_ctx_switch_tb
